// file: shared/nlif_pkg.sv
package nlif_pkg;

  localparam int NLIF_POINTS = 32;
  localparam int NLIF_CLK_MHZ = 125;
  localparam int NLIF_FILT_SHORT_MS = 1;
  localparam int NLIF_FILT_LONG_MS = 10;
  localparam int NLIF_CYC_PER_MS = NLIF_CLK_MHZ * 1000;
  localparam int NLIF_SHORT_CYC = NLIF_FILT_SHORT_MS * NLIF_CYC_PER_MS;
  localparam int NLIF_LONG_CYC = NLIF_FILT_LONG_MS * NLIF_CYC_PER_MS;
  localparam int NLIF_CNT_W = 21;
  localparam int NLIF_FIRST = 0;

  typedef enum logic [1:0]
  {
    NLIF_EDGE_RISE = 2'b01,
    NLIF_EDGE_FALL = 2'b10
  } nlif_edge_e;

  typedef struct packed
  {
    logic filter_long;
    logic irq_enable;
    logic irq_on_fall;
  } nlif_cfg_s;

endpackage : nlif_pkg

// file: verif/nlif_field_model.sv
`timescale 1ns/10ps
module nlif_field_model
  import nlif_pkg::*;
(
  input wire logic clock,
  input wire logic [NLIF_POINTS-1:0] want_on,
  output logic [NLIF_POINTS-1:0] field_pin
);
  // pull-ups hold every pin high until a contact closes
  initial
  begin
    field_pin = '1;
    forever @(posedge clock) field_pin <= ~want_on;
  end
endmodule : nlif_field_model

// file: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import nlif_pkg::*;
;
  localparam int SC = 4;
  localparam int LC = 20;
  logic clock = 0;
  logic reset = 1;
  logic [31:0] want_on = '0;
  logic [31:0] field_pin, point_on, indicator, prev, r, e;
  nlif_cfg_s cfg = '0;
  logic irq;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] q_on [$];
  int q_irq [$];
  always #4 clock = ~clock;
  nlif_field_model u_nlif_field_model (.clock(clock), .want_on(want_on),
    .field_pin(field_pin));
  nlif_input_port #(.SHORT_CYC(SC), .LONG_CYC(LC)) u_nlif_input_port (
    .clock(clock), .reset(reset), .field_pin(field_pin), .cfg(cfg),
    .point_on(point_on), .indicator(indicator), .irq(irq));
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [31:0] ex, got);
    checked++;
    if (got !== ex)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, ex, got);
    end
  endtask : cmp
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // irq lands five negedges on: model register, two syncs, irq register
  task automatic put(input logic [31:0] v, input bit note);
    @(posedge clock);
    if (cfg.irq_enable && v[0] != want_on[0] && v[0] != cfg.irq_on_fall)
      q_irq.push_back(cyc + 5);
    want_on <= v;
    if (note)
      q_on.push_back(v);
  endtask : put
  //////////////////////////////////////////////////////////////////////////
  // an unannounced change of point_on is checked against the old value
  always @(negedge clock)
  begin
    cyc++;
    if (!reset && point_on !== prev)
    begin
      e = q_on.size() ? q_on.pop_front() : prev;
      cmp("point_on", e, point_on);
      cmp("indicator", e, indicator);
    end
    if (irq === 1'b1)
    begin
      e = q_irq.size() ? 32'(q_irq.pop_front()) : '1;
      cmp("irq_cycle", e, 32'(cyc));
    end
    prev = point_on;
  end
  initial
  begin
    #(8 * 5000);
    fails++;
    results();
  end
  initial
  begin
    void'($urandom(32'hec2c_aefa));
    tick(10);
    reset <= 0;
    @(negedge clock);
    cmp("reset_on", 32'h0000_0000, point_on);
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom();
      put(r, 1);
      tick(SC + 8);
    end
    r = want_on;
    put(r ^ 32'h0f0f_0000, 0);
    tick(SC - 2);
    put(r, 0);
    tick(SC + 8);
    cfg <= '{1'b1, 1'b0, 1'b0};
    tick(4);
    put(~want_on, 1);
    tick(SC + 8);
    cmp("long_wait", 32'h0000_0001, 32'(q_on.size()));
    tick(LC);
    cmp("long_done", 32'h0000_0000, 32'(q_on.size()));
    for (int m = 0; m < 5; m++)
    begin
      cfg <= '{m[0], m < 4, m[1]};
      tick(4);
      put(want_on ^ 32'h0000_0021, 1);
      tick(LC + 8);
      put(want_on ^ 32'h0000_0001, 1);
      tick(LC + 8);
      put(want_on ^ 32'h0000_0002, 1);
      tick(LC + 8);
    end
    // mid-run reset: states clear, then refilter the held pins
    reset <= 1'b1;
    tick(3);
    cmp("reset_mid", 32'h0000_0000, indicator);
    q_on.push_back(want_on);
    reset <= 1'b0;
    tick(SC + 8);
    @(negedge clock);
    cmp("queues", 32'h0000_0000, 32'(q_on.size() + q_irq.size()));
    results();
  end
endmodule : tb_top

// file: verilog/nlif_input_port.sv
`timescale 1ns/10ps
module nlif_input_port
  import nlif_pkg::*;
#(
  parameter int POINTS = NLIF_POINTS,
  parameter int SHORT_CYC = NLIF_SHORT_CYC,
  parameter int LONG_CYC = NLIF_LONG_CYC
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [POINTS-1:0] field_pin,
  input wire nlif_cfg_s cfg,
  output logic [POINTS-1:0] point_on,
  output logic [POINTS-1:0] indicator,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // synchroniser: stage one feeds only stage two
  logic [POINTS-1:0] sync_a;
  logic [POINTS-1:0] sync_b;
  logic [POINTS-1:0] raw_on;
  logic [POINTS-1:0] filt_on;
  logic [NLIF_CNT_W-1:0] limit;
  logic prev_first;
  logic next_prev_first;
  logic next_irq;
  logic [POINTS-1:0] next_point_on;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync_a <= '1;
      sync_b <= '1;
    end
    else
    begin
      sync_a <= field_pin;
      sync_b <= sync_a;
    end
  end

  assign raw_on = ~sync_b;

  ////////////////////////////////////////////////////////////////////////
  // one limit for the whole module; per-point times are not offered
  always_comb
  begin
    if (cfg.filter_long)
    begin
      limit = NLIF_CNT_W'(LONG_CYC);
    end
    else
    begin
      limit = NLIF_CNT_W'(SHORT_CYC);
    end
  end

  for (genvar i = 0; i < POINTS; i++)
  begin : g_pt
    nlif_point_filter #(.CNT_W(NLIF_CNT_W)) u_filt
    (
      .clock(clock),
      .reset(reset),
      .raw_on(raw_on[i]),
      .limit(limit),
      .state_on(filt_on[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt edge on raw (pre-filter) first point; one-cycle pulse
  always_comb
  begin
    next_prev_first = raw_on[NLIF_FIRST];
    next_irq = 1'b0;
    if (cfg.irq_enable)
    begin
      if (cfg.irq_on_fall)
      begin
        next_irq = prev_first & ~raw_on[NLIF_FIRST];
      end
      else
      begin
        next_irq = ~prev_first & raw_on[NLIF_FIRST];
      end
    end
    next_point_on = filt_on;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      prev_first <= 1'b0;
      irq <= 1'b0;
      point_on <= '0;
    end
    else
    begin
      prev_first <= next_prev_first;
      irq <= next_irq;
      point_on <= next_point_on;
    end
  end

  assign indicator = point_on;

  ////////////////////////////////////////////////////////////////////////
  // checker-only run length of the watched point away from its filtered
  // state; kept apart from the filter's own counter so that a broken
  // count there cannot hide itself
  localparam int WATCH = POINTS - 1;
  logic [NLIF_CNT_W-1:0] chk_run;
  logic [NLIF_CNT_W-1:0] next_chk_run;

  always_comb
  begin
    next_chk_run = '0;
    if (raw_on[WATCH] != filt_on[WATCH])
    begin
      next_chk_run = chk_run + 1'h1;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      chk_run <= '0;
    end
    else
    begin
      chk_run <= next_chk_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_rise;
    !prev_first ##0 raw_on[NLIF_FIRST];
  endsequence

  sequence s_fall;
    prev_first ##0 !raw_on[NLIF_FIRST];
  endsequence

  a_irq_rise_edge: assert property (@(posedge clock)
    disable iff (reset)
    (cfg.irq_enable && !cfg.irq_on_fall) ##0 s_rise |=> irq)
    else $error("rise edge missed");

  a_irq_fall_edge: assert property (@(posedge clock)
    disable iff (reset)
    (cfg.irq_enable && cfg.irq_on_fall) ##0 s_fall |=> irq)
    else $error("fall edge missed");

  a_irq_off_quiet: assert property (@(posedge clock)
    disable iff (reset)
    !cfg.irq_enable |=> !irq)
    else $error("irq while disabled");

  a_irq_needs_enable: assert property (@(posedge clock)
    disable iff (reset)
    irq |-> $past(cfg.irq_enable))
    else $error("irq without enable");

  a_irq_direction: assert property (@(posedge clock)
    disable iff (reset)
    irq |-> $past(raw_on[NLIF_FIRST]) != $past(cfg.irq_on_fall))
    else $error("irq on wrong edge");

  a_irq_pre_filter: assert property (@(posedge clock)
    disable iff (reset)
    irq |-> $past(raw_on[NLIF_FIRST]) != $past(prev_first))
    else $error("irq without raw edge");

  a_polarity_map: assert property (@(posedge clock)
    disable iff (reset)
    !$past(reset, 2) |-> raw_on == ~$past(field_pin, 2))
    else $error("polarity wrong");

  a_led_follow: assert property (@(posedge clock)
    disable iff (reset)
    indicator == $past(filt_on))
    else $error("indicator mismatch");

  a_first_data: assert property (@(posedge clock)
    disable iff (reset)
    point_on[NLIF_FIRST] == $past(filt_on[NLIF_FIRST]))
    else $error("first point data lost");

  a_filter_hold: assert property (@(posedge clock)
    disable iff (reset)
    $changed(filt_on[WATCH]) |-> $past(raw_on[WATCH]) == filt_on[WATCH])
    else $error("filter changed toward wrong level");

  a_filter_settle: assert property (@(posedge clock)
    disable iff (reset)
    $changed(filt_on[WATCH]) |-> chk_run >= $past(limit))
    else $error("filter settled early");

  a_point_rest: assert property (@(posedge clock)
    disable iff (reset)
    ((filt_on ^ $past(filt_on)) & ~($past(raw_on) ^ $past(filt_on))) == '0)
    else $error("filter moved without a raw change");

  a_point_to_raw: assert property (@(posedge clock)
    disable iff (reset)
    ((filt_on ^ $past(filt_on)) & (filt_on ^ $past(raw_on))) == '0)
    else $error("filter moved away from raw level");

  a_limit_sel: assert property (@(posedge clock)
    disable iff (reset)
    limit == (cfg.filter_long ? NLIF_CNT_W'(LONG_CYC)
                              : NLIF_CNT_W'(SHORT_CYC)))
    else $error("filter limit wrong");

endmodule : nlif_input_port

// file: verilog/nlif_point_filter.sv
`timescale 1ns/10ps
module nlif_point_filter
  import nlif_pkg::*;
#(
  parameter int CNT_W = NLIF_CNT_W
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic raw_on,
  input wire logic [CNT_W-1:0] limit,
  output logic state_on
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_state_on;

  // the count runs only while raw disagrees with state; any bounce back
  // to the held level clears it, so a new level must stay for the full time
  always_comb
  begin
    next_count = '0;
    next_state_on = state_on;
    if (raw_on != state_on)
    begin
      if (count + 1'b1 >= limit)
      begin
        next_state_on = raw_on;
      end
      else
      begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      count <= '0;
      state_on <= 1'b0;
    end
    else
    begin
      count <= next_count;
      state_on <= next_state_on;
    end
  end

endmodule : nlif_point_filter
